// *** rtl/uart_status_monitor.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_monitor_defines.svh"
module uart_status_monitor #(
    parameter bit ROMLESS = 1'b1
) (
    // Clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                nrst,
    // Register port
    input  wire logic [8:0]                          addr,
    input  wire logic [7:0]                          wdata,
    input  wire logic                                wr_stb,
    input  wire logic                                rd_stb,
    output logic      [7:0]                          rdata,
    // Modem lines and control
    input  wire uart_status_monitor_pkg::modem_in_s  modem_in,
    input  wire uart_status_monitor_pkg::modem_ctrl_s modem_ctrl,
    input  wire logic                                parallel_mode,
    input  wire logic                                break_control_bit,
    input  wire logic                                rx_pin_sample,
    // Host side activity
    input  wire uart_status_monitor_pkg::host_evt_s  host_evt,
    // Outputs to the UART core
    output logic                                     modem_status_irq,
    output logic                                     rxtx_reset,
    output logic                                     command_modem_select,
    output logic                                     echo_enable
);
    uart_status_monitor_pkg::state_s st_reg;
    uart_status_monitor_pkg::state_s st_next;
    logic [7:0] msr_view;
    logic [3:0] cur_in;
    logic       rd_lsr;
    logic       rd_msr;
    logic       rd_mon;
    logic       rd_buf_ready;
    // Idle pins read as inverted levels, ring as is, so the edge memory starts there
    localparam uart_status_monitor_pkg::state_s ST_RESET = '{prev_in: `MSR_IDLE_INPUTS,
                                                             default: '0};

    // Inverted inputs, ring kept as is; loopback swaps in modem control bits
    always_comb begin
        if (modem_ctrl.loop_en) begin
            cur_in = {modem_ctrl.aux_output_two, modem_ctrl.aux_output_one,
                      modem_ctrl.dtr, modem_ctrl.rts};
        end else begin
            cur_in = {~modem_in.dcd, modem_in.ri, ~modem_in.dsr, ~modem_in.cts};
        end
    end

    // Status view of the modem line register
    always_comb begin
        msr_view      = {cur_in, st_reg.delta_flags};
        if (!modem_ctrl.loop_en && parallel_mode) begin
            msr_view[7] = st_reg.dcd_wr;
        end
        if (!modem_ctrl.loop_en && ROMLESS) begin
            msr_view[6] = st_reg.ring_latch_bit;
        end
    end

    assign rd_lsr       = rd_stb && (addr == `OFS_LINE_STATE_FLAGS);
    assign rd_msr       = rd_stb && (addr == `OFS_MODEM_LINE_STATE);
    assign rd_mon       = rd_stb && (addr == `OFS_ACTIVITY_MONITOR);
    assign rd_buf_ready = host_evt.rx_buf_read;

    // Next state: clears first, then sets so events are never lost
    always_comb begin
        st_next = st_reg;
        st_next.prev_in = cur_in;
        st_next.rdata   = 8'h00;
        // Reads return data and clear flags
        if (rd_stb) begin
            case (addr)
                `OFS_LINE_STATE_FLAGS: st_next.rdata = {5'h00, st_reg.line_flags};
                `OFS_MODEM_LINE_STATE: st_next.rdata = msr_view;
                `OFS_SCRATCH_BYTE:     st_next.rdata = st_reg.scratch;
                `OFS_ACTIVITY_MONITOR: st_next.rdata = {st_reg.monitor[7:6], rx_pin_sample,
                                                        st_reg.monitor[4:0]};
                default:               st_next.rdata = 8'h00;
            endcase
        end
        if (rd_lsr) begin
            st_next.line_flags[`LSR_PE_BIT] = 1'b0;
            st_next.line_flags[`LSR_OE_BIT] = 1'b0;
        end
        if (rd_buf_ready) begin
            st_next.line_flags[`LSR_DR_BIT] = 1'b0;
        end
        if (rd_msr) begin
            st_next.delta_flags = 4'h0;
        end
        if (rd_mon) begin
            st_next.monitor = st_reg.monitor & ~`MON_CLEAR_MASK;
        end
        // Software writes
        if (wr_stb) begin
            case (addr)
                `OFS_SCRATCH_BYTE: st_next.scratch = wdata;
                `OFS_MODEM_LINE_STATE: begin
                    st_next.dcd_wr         = wdata[7];
                    st_next.ring_latch_bit = wdata[6];
                    st_next.delta_flags[`MSR_RING_TRAILING_EDGE_FLAG_BIT] = wdata[`MSR_RING_TRAILING_EDGE_FLAG_BIT];
                end
                `OFS_ACTIVITY_MONITOR: begin
                    st_next.monitor[7:6] = wdata[7:6];
                end
                default: ;
            endcase
        end
        // Hardware sets, winning over any clear above
        if (host_evt.rx_parity_bad) begin
            st_next.line_flags[`LSR_PE_BIT] = 1'b1;
        end
        if (host_evt.rx_char_done) begin
            if (st_reg.line_flags[`LSR_DR_BIT] && !rd_buf_ready) begin
                st_next.line_flags[`LSR_OE_BIT] = 1'b1;
            end
            st_next.line_flags[`LSR_DR_BIT] = 1'b1;
        end
        if (cur_in[3] != st_reg.prev_in[3]) st_next.delta_flags[`MSR_CARRIER_CHANGE_FLAG_BIT] = 1'b1;
        if (cur_in[1] != st_reg.prev_in[1]) st_next.delta_flags[`MSR_SET_READY_CHANGE_FLAG_BIT] = 1'b1;
        if (cur_in[0] != st_reg.prev_in[0]) st_next.delta_flags[`MSR_CLEAR_TO_SEND_CHANGE_FLAG_BIT] = 1'b1;
        if (cur_in[2] && !st_reg.prev_in[2]) st_next.delta_flags[`MSR_RING_TRAILING_EDGE_FLAG_BIT] = 1'b1;
        if (host_evt.divisor_write)    st_next.monitor[4] = 1'b1;
        if (host_evt.line_ctrl_write)  st_next.monitor[3] = 1'b1;
        if (host_evt.tx_char_write)    st_next.monitor[2] = 1'b1;
        if (host_evt.rx_buf_read)      st_next.monitor[1] = 1'b1;
        if (host_evt.modem_ctrl_write) st_next.monitor[0] = 1'b1;
    end

    // State register; prev inputs reset to idle so no spurious change flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata                = st_reg.rdata;
    assign modem_status_irq     = |st_reg.delta_flags;
    assign rxtx_reset           = st_reg.monitor[7];
    assign command_modem_select = st_reg.monitor[6];
    assign echo_enable          = st_reg.monitor[6] & break_control_bit;

    // Checks; all of them live in the one clock domain
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_PE_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
        host_evt.rx_parity_bad |=> st_reg.line_flags[`LSR_PE_BIT])
        else $error("parity flag not set");
    AST_LSR_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_lsr && !host_evt.rx_parity_bad && !host_evt.rx_char_done
        |=> !st_reg.line_flags[`LSR_OE_BIT] && !st_reg.line_flags[`LSR_PE_BIT])
        else $error("line flags not cleared");
    AST_DR_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
        host_evt.rx_char_done |=> st_reg.line_flags[`LSR_DR_BIT])
        else $error("data ready not set");
    AST_IRQ: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cur_in[0] != st_reg.prev_in[0]) |=> modem_status_irq)
        else $error("modem irq mismatch");
    AST_LOOP_DSR: assert property (@(posedge ref_clk) disable iff (!nrst)
        modem_ctrl.loop_en |-> msr_view[5] == modem_ctrl.dtr)
        else $error("loopback set ready mismatch");
    AST_LOOP_CTS: assert property (@(posedge ref_clk) disable iff (!nrst)
        modem_ctrl.loop_en |-> msr_view[4] == modem_ctrl.rts)
        else $error("loopback clear to send mismatch");
    AST_SCRATCH: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_stb && addr == `OFS_SCRATCH_BYTE |=> st_reg.scratch == $past(wdata))
        else $error("scratch not stored");
    AST_MON_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_mon && host_evt == '0 && !wr_stb |=> st_reg.monitor[4:0] == 5'h00
        && st_reg.monitor[7:6] == $past(st_reg.monitor[7:6]))
        else $error("monitor not cleared");
    AST_RDI: assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_mon |=> rdata[5] == $past(rx_pin_sample))
        else $error("receive input not reported");
    AST_TXF: assert property (@(posedge ref_clk) disable iff (!nrst)
        host_evt.tx_char_write |=> st_reg.monitor[2])
        else $error("transmit flag not set");

    // Parity flag never drops without a line flag read
    AST_PE_HOLD: assert property (
        !rd_lsr && !host_evt.rx_parity_bad
        |=> st_reg.line_flags[`LSR_PE_BIT] == $past(st_reg.line_flags[`LSR_PE_BIT]))
        else $error("parity flag changed");

    // Character onto an unread one is an overrun
    AST_OE_SET: assert property (
        host_evt.rx_char_done && st_reg.line_flags[`LSR_DR_BIT] && !rd_buf_ready
        |=> st_reg.line_flags[`LSR_OE_BIT])
        else $error("overrun not set");

    // Overrun flag holds until read
    AST_OE_HOLD: assert property (
        !rd_lsr && !host_evt.rx_char_done
        |=> st_reg.line_flags[`LSR_OE_BIT] == $past(st_reg.line_flags[`LSR_OE_BIT]))
        else $error("overrun flag changed");

    // Buffer read empties data ready
    AST_DR_CLEAR: assert property (
        rd_buf_ready && !host_evt.rx_char_done
        |=> !st_reg.line_flags[`LSR_DR_BIT])
        else $error("data ready not cleared");

    // Data ready holds with no receive activity
    AST_DR_HOLD: assert property (
        !rd_buf_ready && !host_evt.rx_char_done
        |=> st_reg.line_flags[`LSR_DR_BIT] == $past(st_reg.line_flags[`LSR_DR_BIT]))
        else $error("data ready changed");

    // Clear to send change
    AST_CLEAR_TO_SEND_CHANGE_FLAG_SET: assert property (
        cur_in[0] != st_reg.prev_in[0]
        |=> st_reg.delta_flags[`MSR_CLEAR_TO_SEND_CHANGE_FLAG_BIT])
        else $error("clear to send change lost");

    // Set ready change
    AST_SET_READY_CHANGE_FLAG_SET: assert property (
        cur_in[1] != st_reg.prev_in[1]
        |=> st_reg.delta_flags[`MSR_SET_READY_CHANGE_FLAG_BIT])
        else $error("set ready change lost");

    // Carrier change
    AST_CARRIER_CHANGE_FLAG_SET: assert property (
        cur_in[3] != st_reg.prev_in[3]
        |=> st_reg.delta_flags[`MSR_CARRIER_CHANGE_FLAG_BIT])
        else $error("carrier change lost");

    // A quiet status read empties every change flag
    AST_MSR_CLEAR: assert property (
        rd_msr && cur_in == st_reg.prev_in && !wr_stb
        |=> st_reg.delta_flags == 4'h0)
        else $error("change flags not cleared");

    // Change flags only fall through a status read or a status write
    AST_DELTA_HOLD: assert property (
        !rd_msr && !wr_stb
        |=> (st_reg.delta_flags & $past(st_reg.delta_flags)) == $past(st_reg.delta_flags))
        else $error("change flag dropped");

    // Quiet read also drops the interrupt
    AST_IRQ_LOW: assert property (
        rd_msr && cur_in == st_reg.prev_in && !wr_stb
        |=> !modem_status_irq)
        else $error("modem irq stuck");

    // Carrier level, inverted, outside loopback and parallel mode
    AST_DCD_VIEW: assert property (
        !modem_ctrl.loop_en && !parallel_mode
        |-> msr_view[7] == ~modem_in.dcd)
        else $error("carrier level wrong");

    // Loopback carrier comes from aux two
    AST_LOOP_DCD: assert property (
        modem_ctrl.loop_en
        |-> msr_view[7] == modem_ctrl.aux_output_two)
        else $error("loopback carrier wrong");

    // Status write stores the carrier bit in any mode; only parallel mode shows it
    AST_DCD_WRITE: assert property (
        wr_stb && addr == `OFS_MODEM_LINE_STATE
        |=> st_reg.dcd_wr == $past(wdata[7]))
        else $error("carrier bit not stored");

    // Ring latch is written by firmware
    AST_RING_WRITE: assert property (
        wr_stb && addr == `OFS_MODEM_LINE_STATE
        |=> st_reg.ring_latch_bit == $past(wdata[6]))
        else $error("ring latch not stored");

    // Loopback ring comes from aux one
    AST_LOOP_RING: assert property (
        modem_ctrl.loop_en
        |-> msr_view[6] == modem_ctrl.aux_output_one)
        else $error("loopback ring wrong");

    // Ring bit source depends on the variant
    AST_RING_VIEW: assert property (
        !modem_ctrl.loop_en
        |-> msr_view[6] == (ROMLESS ? st_reg.ring_latch_bit : modem_in.ri))
        else $error("ring bit wrong");

    // Set ready level, inverted
    AST_DSR_VIEW: assert property (
        !modem_ctrl.loop_en
        |-> msr_view[5] == ~modem_in.dsr)
        else $error("set ready level wrong");

    // Clear to send level, inverted
    AST_CTS_VIEW: assert property (
        !modem_ctrl.loop_en
        |-> msr_view[4] == ~modem_in.cts)
        else $error("clear to send level wrong");

    // Ring rising edge
    AST_RING_TRAILING_EDGE_FLAG_SET: assert property (
        cur_in[2] && !st_reg.prev_in[2]
        |=> st_reg.delta_flags[`MSR_RING_TRAILING_EDGE_FLAG_BIT])
        else $error("ring edge lost");

    // Firmware may set the ring edge flag
    AST_RING_TRAILING_EDGE_FLAG_WRITE: assert property (
        wr_stb && addr == `OFS_MODEM_LINE_STATE && wdata[`MSR_RING_TRAILING_EDGE_FLAG_BIT]
        |=> st_reg.delta_flags[`MSR_RING_TRAILING_EDGE_FLAG_BIT])
        else $error("ring edge write lost");

    // Scratch byte keeps its value between writes
    AST_SCRATCH_HOLD: assert property (
        !(wr_stb && addr == `OFS_SCRATCH_BYTE)
        |=> st_reg.scratch == $past(st_reg.scratch))
        else $error("scratch changed");

    // Scratch read returns the stored byte
    AST_SCRATCH_READ: assert property (
        rd_stb && addr == `OFS_SCRATCH_BYTE
        |=> rdata == $past(st_reg.scratch))
        else $error("scratch read wrong");

    // Monitor read shows the flags before clearing them
    AST_MON_READ: assert property (
        rd_mon
        |=> rdata[4:0] == $past(st_reg.monitor[4:0]))
        else $error("monitor flags not shown");

    // Receiver and transmitter reset follows bit 7
    AST_RXTX_RESET: assert property (
        wr_stb && addr == `OFS_ACTIVITY_MONITOR
        |=> rxtx_reset == $past(wdata[7]))
        else $error("rxtx reset not stored");

    // Mode select follows bit 6
    AST_MODE_WRITE: assert property (
        wr_stb && addr == `OFS_ACTIVITY_MONITOR
        |=> command_modem_select == $past(wdata[6]))
        else $error("mode not stored");

    // Mode select holds between writes
    AST_MODE_HOLD: assert property (
        !(wr_stb && addr == `OFS_ACTIVITY_MONITOR)
        |=> command_modem_select == $past(command_modem_select))
        else $error("mode changed");

    // Echo needs both the mode bit and the break bit
    AST_ECHO: assert property (
        command_modem_select && break_control_bit
        |-> echo_enable)
        else $error("echo not enabled");

    // Host writes leave their tracking flags
    AST_DLF: assert property (
        host_evt.divisor_write |=> st_reg.monitor[4])
        else $error("divisor flag not set");

    AST_LCF: assert property (
        host_evt.line_ctrl_write |=> st_reg.monitor[3])
        else $error("line control flag not set");

    AST_MCF: assert property (
        host_evt.modem_ctrl_write |=> st_reg.monitor[0])
        else $error("modem control flag not set");

    // Host buffer read
    AST_RXF: assert property (
        host_evt.rx_buf_read |=> st_reg.monitor[1])
        else $error("buffer read flag not set");

    // A clearing read must not swallow a same-cycle event
    AST_RACE_KEEP: assert property (
        rd_mon && host_evt.tx_char_write |=> st_reg.monitor[2])
        else $error("event lost to read");
    COV_OVERRUN: cover property (@(posedge ref_clk) disable iff (!nrst)
        host_evt.rx_char_done ##1 host_evt.rx_char_done ##1 st_reg.line_flags[`LSR_OE_BIT]);
    COV_LOOP: cover property (@(posedge ref_clk) disable iff (!nrst)
        modem_ctrl.loop_en && modem_status_irq);
    COV_MON_RACE: cover property (@(posedge ref_clk) disable iff (!nrst)
        rd_mon && host_evt.divisor_write);
    COV_PARALLEL_DCD: cover property (@(posedge ref_clk) disable iff (!nrst)
        parallel_mode && wr_stb && addr == `OFS_MODEM_LINE_STATE);
    COV_RING_EDGE: cover property (@(posedge ref_clk) disable iff (!nrst)
        cur_in[2] && !st_reg.prev_in[2]);
endmodule
`default_nettype wire

// *** rtl/uart_status_monitor_defines.svh ***
`ifndef UART_STATUS_MONITOR_DEFINES_SVH
`define UART_STATUS_MONITOR_DEFINES_SVH
`define OFS_LINE_STATE_FLAGS  9'h185
`define OFS_MODEM_LINE_STATE  9'h186
`define OFS_SCRATCH_BYTE      9'h187
`define OFS_ACTIVITY_MONITOR  9'h18b
`define LSR_DR_BIT            0
`define LSR_OE_BIT            1
`define LSR_PE_BIT            2
`define MSR_CLEAR_TO_SEND_CHANGE_FLAG_BIT          0
`define MSR_SET_READY_CHANGE_FLAG_BIT          1
`define MSR_RING_TRAILING_EDGE_FLAG_BIT          2
`define MSR_CARRIER_CHANGE_FLAG_BIT          3
`define MON_CLEAR_MASK        8'h1f
`define MSR_IDLE_INPUTS       4'hb
`define MON_RESET_VALUE       8'h00
`define SCRATCH_RESET_VALUE   8'h00
`endif

// *** rtl/uart_status_monitor_pkg.sv ***
package uart_status_monitor_pkg;
    // Modem control bits that feed loopback
    typedef struct packed {
        logic loop_en;
        logic aux_output_two;
        logic aux_output_one;
        logic rts;
        logic dtr;
    } modem_ctrl_s;
    // Raw modem inputs, as seen on the pins
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } modem_in_s;
    // Host side UART activity events, one-cycle pulses
    typedef struct packed {
        logic rx_char_done;
        logic rx_parity_bad;
        logic rx_buf_read;
        logic divisor_write;
        logic line_ctrl_write;
        logic modem_ctrl_write;
        logic tx_char_write;
    } host_evt_s;
    // Whole module state
    typedef struct packed {
        logic [2:0] line_flags;
        logic [3:0] delta_flags;
        logic [3:0] prev_in;
        logic       dcd_wr;
        logic       ring_latch_bit;
        logic [7:0] scratch;
        logic [7:0] monitor;
        logic [7:0] rdata;
    } state_s;
endpackage

// *** dv/modem_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module modem_far_end (
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              nrst,
    // Line change request from the bench
    input  wire logic                              load,
    input  wire uart_status_monitor_pkg::modem_in_s next_lines,
    // Modem pins seen by the block
    output var  uart_status_monitor_pkg::modem_in_s modem_in
);
    // Lines hold between requests, as a real modem would
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            modem_in <= '0;
        end else if (load) begin
            modem_in <= next_lines;
        end
    end
endmodule
`default_nettype wire

// *** dv/uart_status_monitor_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uart_status_monitor_defines.svh"
module uart_status_monitor_test;
    // Bench drives and design outputs
    logic                                 ref_clk = 1'b0;
    logic                                 nrst = 1'b0;
    logic [8:0]                           addr = 9'h000;
    logic [7:0]                           wdata = 8'h00;
    logic                                 wr_stb = 1'b0;
    logic                                 rd_stb = 1'b0;
    logic                                 load = 1'b0;
    logic                                 brk = 1'b0;
    logic                                 rx_in = 1'b0;
    logic                                 par = 1'b0;
    logic [7:0]                           sv;
    logic [7:0]                           rdata;
    logic                                 irq, rst_out, mode_out, echo;
    logic [3:0]                           cur, old;
    logic [6:0]                           e;
    uart_status_monitor_pkg::modem_in_s   next_lines = '0;
    uart_status_monitor_pkg::modem_in_s   lines;
    uart_status_monitor_pkg::modem_ctrl_s mctl = '0;
    uart_status_monitor_pkg::host_evt_s   evt = '0;
    int                                   err_count = 0;
    int                                   total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    // Design and far side
    uart_status_monitor uart_status_monitor_inst (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .modem_in(lines),
        .modem_ctrl(mctl), .parallel_mode(par), .break_control_bit(brk),
        .rx_pin_sample(rx_in), .host_evt(evt), .modem_status_irq(irq),
        .rxtx_reset(rst_out), .command_modem_select(mode_out), .echo_enable(echo));
    modem_far_end modem_far_end_inst (.ref_clk(ref_clk), .nrst(nrst), .load(load),
        .next_lines(next_lines), .modem_in(lines));
    // Expected status byte: inverted levels and ring latch above, change flags below
    function automatic logic [7:0] msr_exp(input logic [3:0] l, input logic [3:0] o,
                                           input logic rl);
        return {~l[3], rl, ~l[1], ~l[0], l[3] ^ o[3], l[2] & ~o[2], l[1] ^ o[1], l[0] ^ o[0]};
    endfunction
    // Expected monitor byte for one burst of host events
    function automatic logic [7:0] mon_exp(input logic [6:0] v, input logic r);
        return {2'b00, r, v[3], v[2], v[0], v[4], v[1]};
    endfunction
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus cycles: strobe for one cycle, read data checked in the next
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 chk(rdata & m, exp);
    endtask
    task automatic pulse(input logic [6:0] v, input logic r);
        @(posedge ref_clk);
        evt <= v;
        rx_in <= r;
        @(posedge ref_clk);
        evt <= '0;
    endtask
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hd932));
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(`OFS_LINE_STATE_FLAGS, 8'hff, 8'h00);
        rd(`OFS_MODEM_LINE_STATE, 8'hff, 8'hb0);
        rd(`OFS_ACTIVITY_MONITOR, 8'hff, 8'h00);
        rd(9'h1ff, 8'hff, 8'h00);
        repeat (4) begin
            sv = $urandom;
            wr(`OFS_SCRATCH_BYTE, sv);
            rd(`OFS_SCRATCH_BYTE, 8'hff, sv);
        end
        // Bad parity, then overrun on an unread character, then buffer read
        pulse(7'h60, 1'b0);
        rd(`OFS_LINE_STATE_FLAGS, 8'hff, 8'h05);
        rd(`OFS_LINE_STATE_FLAGS, 8'hff, 8'h01);
        pulse(7'h40, 1'b0);
        rd(`OFS_LINE_STATE_FLAGS, 8'hff, 8'h03);
        rd(`OFS_LINE_STATE_FLAGS, 8'hff, 8'h01);
        pulse(7'h10, 1'b0);
        rd(`OFS_LINE_STATE_FLAGS, 8'hff, 8'h00);
        rd(`OFS_ACTIVITY_MONITOR, 8'hff, 8'h02);
        // Firmware polls the monitor instead of the interrupt id register
        repeat (8) begin
            e = 7'($urandom) & 7'h1f;
            pulse(e, 1'($urandom));
            rd(`OFS_ACTIVITY_MONITOR, 8'hff, mon_exp(e, rx_in));
            rd(`OFS_ACTIVITY_MONITOR, 8'h1f, 8'h00);
        end
        // Event landing in the same cycle as the clearing read
        @(posedge ref_clk);
        addr <= `OFS_ACTIVITY_MONITOR;
        rd_stb <= 1'b1;
        evt <= 7'h01;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        evt <= '0;
        rd(`OFS_ACTIVITY_MONITOR, 8'h1f, 8'h04);
        // Mode bits; break bit kept set for normal operation
        wr(`OFS_ACTIVITY_MONITOR, 8'hc0);
        @(posedge ref_clk);
        brk <= 1'b1;
        @(posedge ref_clk);
        #1 chk({5'h00, rst_out, mode_out, echo}, 8'h07);
        wr(`OFS_ACTIVITY_MONITOR, 8'h40);
        rd(`OFS_ACTIVITY_MONITOR, 8'hc0, 8'h40);
        #1 chk({5'h00, rst_out, mode_out, echo}, 8'h03);
        wr(`OFS_ACTIVITY_MONITOR, 8'h00);
        // Random modem line changes
        old = 4'h0;
        repeat (10) begin
            cur = 4'($urandom);
            @(posedge ref_clk);
            next_lines <= cur;
            load <= 1'b1;
            @(posedge ref_clk);
            load <= 1'b0;
            repeat (3) @(posedge ref_clk);
            #1 chk({7'h00, irq}, {7'h00, (msr_exp(cur, old, 1'b0) & 8'h0f) != 8'h00});
            rd(`OFS_MODEM_LINE_STATE, 8'hff, msr_exp(cur, old, 1'b0));
            old = cur;
        end
        wr(`OFS_MODEM_LINE_STATE, 8'h44);
        rd(`OFS_MODEM_LINE_STATE, 8'hff, msr_exp(cur, cur, 1'b1) | 8'h04);
        rd(`OFS_MODEM_LINE_STATE, 8'h4f, 8'h40);
        // Loopback maps the control bits onto the upper status bits
        repeat (4) begin
            @(posedge ref_clk);
            mctl <= {1'b1, 4'($urandom)};
            repeat (3) @(posedge ref_clk);
            rd(`OFS_MODEM_LINE_STATE, 8'hf0, {mctl[3:2], mctl[0], mctl[1], 4'h0});
        end
        // Parallel host mode: carrier bit becomes writable
        @(posedge ref_clk);
        mctl <= '0;
        par <= 1'b1;
        wr(`OFS_MODEM_LINE_STATE, 8'h00);
        rd(`OFS_MODEM_LINE_STATE, 8'h80, 8'h00);
        wr(`OFS_MODEM_LINE_STATE, 8'h80);
        rd(`OFS_MODEM_LINE_STATE, 8'h80, 8'h80);
        give_verdict();
    end
endmodule
`default_nettype wire
